// ===== hw/svwr_pkg.sv
package svwr_pkg;

    // ---------------------------------------------------------------
    // Clock and time base.
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    // Internal tick period in ns: one slow watchdog period spans 1024 ticks.
    localparam int TICK_NS = 1562500;
    localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;

    // ---------------------------------------------------------------
    // Timeouts on the internal oscillator, in ms, and in ticks.
    // ---------------------------------------------------------------
    localparam int WD_FAST_MS = 100;
    localparam int WD_SLOW_MS = 1600;
    localparam int RST_MS = 200;
    localparam logic [12:0] INT_WD_FAST = 13'(WD_FAST_MS * 1000 / (TICK_NS / 1000));
    localparam logic [12:0] INT_WD_SLOW = 13'(WD_SLOW_MS * 1000 / (TICK_NS / 1000));
    localparam logic [12:0] INT_RST = 13'(RST_MS * 1000 / (TICK_NS / 1000));

    // ---------------------------------------------------------------
    // Timeouts on the external source, in source clocks.
    // ---------------------------------------------------------------
    localparam logic [12:0] EXT_WD_NORM = 13'h0400;
    localparam logic [12:0] EXT_WD_FIRST = 13'h1000;
    localparam logic [12:0] EXT_RST = 13'h0800;

    // ---------------------------------------------------------------
    // Chip-select hold after reset assertion.
    // ---------------------------------------------------------------
    localparam int CS_HOLD_NS = 16000;
    localparam logic [10:0] CS_HOLD_CYC = 11'(CS_HOLD_NS / CLK_PERIOD_NS);

    // ---------------------------------------------------------------
    // Register map.
    // ---------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] EVENTS_OFS = 8'h08;
    localparam int CTRL_WD_EN_BIT = 0;
    localparam logic CTRL_WD_EN_RST = 1'b1;
    localparam logic [7:0] EVENTS_RST = 8'h00;
    // Synchroniser reset levels, from bit 7 down: select idle, pin low, internal source,
    // activity low, activity mid, aux below, backup not below, supply below.
    localparam logic [7:0] SYNC_RST = 8'hAD;

    typedef enum logic [2:0] {
        ST_SUPPLY_LOW = 3'b001,
        ST_RESET_HOLD = 3'b010,
        ST_RUN = 3'b100
    } svwr_state_type;

    typedef enum logic [2:0] {
        CS_PASS = 3'b001,
        CS_HOLD = 3'b010,
        CS_BLOCK = 3'b100
    } svwr_cs_type;

    typedef enum logic [1:0] {
        SEL_CTRL = 2'd0,
        SEL_STATUS = 2'd1,
        SEL_EVENTS = 2'd2,
        SEL_NONE = 2'd3
    } svwr_sel_type;

endpackage

// ===== hw/svwr_cond_if.sv
`timescale 1ns/10ps
interface svwr_cond_if;
    logic supply_below;
    logic backup_below;
    logic aux_below;
    logic act_mid;
    logic act_level;
    logic src_sel;
    logic src_pin;
    logic sel_in_n;
    modport src (
        output supply_below, backup_below, aux_below, act_mid, act_level,
        output src_sel, src_pin, sel_in_n
    );
    modport dst (
        input supply_below, backup_below, aux_below, act_mid, act_level,
        input src_sel, src_pin, sel_in_n
    );
endinterface

// ===== hw/svwr_sync.sv
`timescale 1ns/10ps
module svwr_sync
    import svwr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] raw,
    svwr_cond_if.src c
);
    logic [7:0] meta_ff;
    logic [7:0] sync_ff;
    logic [7:0] nxt_meta;
    logic [7:0] nxt_sync;

    // ---------------------------------------------------------------
    // Two-stage synchronisers, one per pin.
    // ---------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_sync
            always_comb begin
                nxt_meta[i] = raw[i];
                nxt_sync[i] = meta_ff[i];
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // Safe levels, so no output claims a good supply before the pins arrive.
            meta_ff <= SYNC_RST;
            sync_ff <= SYNC_RST;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    // Order matches the raw bus in the top module.
    assign c.supply_below = sync_ff[0];
    assign c.backup_below = sync_ff[1];
    assign c.aux_below = sync_ff[2];
    assign c.act_mid = sync_ff[3];
    assign c.act_level = sync_ff[4];
    assign c.src_sel = sync_ff[5];
    assign c.src_pin = sync_ff[6];
    assign c.sel_in_n = sync_ff[7];
endmodule

// ===== hw/svwr_supervisor.sv
`timescale 1ns/10ps
// What this block does
// - Timeouts come from fixed counts of ticks.
// - Mid-level activity input disables the watchdog.
// - supply_low_n follows supply threshold without delay.
// - Select high: internal oscillator, pin picks speed.
// - Select low: timing pin clocks all timeouts.
// - aux_fail_n low while auxiliary input is high.
// - Auxiliary comparison affects nothing else.
// - Stalled activity: flag low, reset pulse.
// - Flag stays low until next activity transition.
// - Mid-level activity input holds flag high.
// - Select held low at most 16 us.
// - Reset during low supply plus timeout after.
// - Open-drain high reset inverts low reset.
// - backup_active shows backup supply in use.
// - Backup mode does not itself drive reset.
// - Each activity transition restarts the watchdog.
// - Both high: 1.6 s watchdog, 200 ms reset.
// - Pin low: 100 ms normal, 1.6 s first.
// - Low supply disables watchdog, flag high.
module svwr_supervisor
    import svwr_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic supply_below_thr,
    input wire logic supply_below_backup,
    input wire logic aux_monitor_input,
    input wire logic activity_mid,
    input wire logic activity_input,
    input wire logic timing_source_select,
    input wire logic timing_source_pin,
    input wire logic select_in_n,
    output logic reset_n,
    output logic reset_hi_o,
    output logic reset_hi_oe,
    output logic supply_low_n,
    output logic aux_fail_n,
    output logic backup_active,
    output logic timeout_flag_n,
    output logic select_out_n
);

    // ---------------------------------------------------------------
    // Helpers.
    // ---------------------------------------------------------------
    function automatic svwr_sel_type reg_sel(input logic [7:0] a);
        case (a)
            CTRL_OFS: reg_sel = SEL_CTRL;
            STATUS_OFS: reg_sel = SEL_STATUS;
            EVENTS_OFS: reg_sel = SEL_EVENTS;
            default: reg_sel = SEL_NONE;
        endcase
    endfunction

    // The capacitor source behaves like an external clock; only the rate differs.
    function automatic logic [12:0] wd_limit(input logic ext, input logic pin,
                                             input logic first);
        if (ext) begin
            wd_limit = first ? EXT_WD_FIRST : EXT_WD_NORM;
        end else if (!pin) begin
            wd_limit = first ? INT_WD_SLOW : INT_WD_FAST;
        end else begin
            wd_limit = INT_WD_SLOW;
        end
    endfunction

    // ---------------------------------------------------------------
    // Synchronised conditions.
    // ---------------------------------------------------------------
    svwr_cond_if c ();

    svwr_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .raw({select_in_n, timing_source_pin, timing_source_select, activity_input,
              activity_mid, aux_monitor_input, supply_below_backup, supply_below_thr}),
        .c(c)
    );

    // ---------------------------------------------------------------
    // State.
    // ---------------------------------------------------------------
    svwr_state_type state_ff, nxt_state;
    svwr_cs_type cs_ff, nxt_cs;
    logic [17:0] presc_ff, nxt_presc;
    logic [12:0] rst_cnt_ff, nxt_rst_cnt;
    logic [12:0] wd_cnt_ff, nxt_wd_cnt;
    logic [10:0] cs_cnt_ff, nxt_cs_cnt;
    logic pin_prev_ff, nxt_pin_prev;
    logic act_prev_ff, nxt_act_prev;
    logic first_ff, nxt_first;
    logic flag_ff, nxt_flag;
    logic reset_n_ff, nxt_reset_n;
    logic supply_low_n_ff, nxt_supply_low_n;
    logic aux_fail_n_ff, nxt_aux_fail_n;
    logic backup_ff, nxt_backup;
    logic sel_out_n_ff, nxt_sel_out_n;
    logic wd_en_ff, nxt_wd_en;
    logic [7:0] evt_ff, nxt_evt;
    logic [31:0] prdata_ff, nxt_prdata;
    logic ext_mode, tick, act_edge, wd_on, timeout;
    logic [12:0] rst_limit;

    // ---------------------------------------------------------------
    // Timebase and watchdog.
    // ---------------------------------------------------------------
    always_comb begin
        ext_mode = !c.src_sel;
        // One tick serves both counters, so their ratio never drifts.
        tick = ext_mode ? (c.src_pin && !pin_prev_ff)
                        : (presc_ff == 18'(TICK_CYCLES - 1));
        nxt_presc = (ext_mode || tick) ? 18'h0_0000 : presc_ff + 18'h0_0001;
        nxt_pin_prev = c.src_pin;
        rst_limit = ext_mode ? EXT_RST : INT_RST;
        act_edge = (c.act_level != act_prev_ff) && !c.act_mid;
        nxt_act_prev = c.act_level;
        wd_on = (state_ff == ST_RUN) && !c.act_mid && !c.supply_below && wd_en_ff;
        timeout = wd_on && tick && !act_edge &&
                  (wd_cnt_ff == wd_limit(ext_mode, c.src_pin, first_ff) - 13'h0001);
        nxt_wd_cnt = wd_cnt_ff;
        nxt_first = first_ff;
        if (!wd_on || act_edge || timeout) begin
            nxt_wd_cnt = 13'h0000;
        end else if (tick) begin
            nxt_wd_cnt = wd_cnt_ff + 13'h0001;
        end
        if (state_ff != ST_RUN) begin
            nxt_first = 1'b1;
        end else if (act_edge) begin
            nxt_first = 1'b0;
        end
        nxt_flag = flag_ff;
        if (c.supply_below || c.act_mid) begin
            nxt_flag = 1'b1;
        end else if (act_edge) begin
            nxt_flag = 1'b1;
        end else if (timeout) begin
            nxt_flag = 1'b0;
        end
        nxt_evt = timeout ? evt_ff + 8'h01 : evt_ff;
    end

    // ---------------------------------------------------------------
    // Reset sequencing.
    // ---------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_rst_cnt = rst_cnt_ff;
        case (state_ff)
            ST_SUPPLY_LOW: begin
                nxt_rst_cnt = 13'h0000;
                if (!c.supply_below) begin
                    nxt_state = ST_RESET_HOLD;
                end
            end
            ST_RESET_HOLD: begin
                if (tick) begin
                    nxt_rst_cnt = rst_cnt_ff + 13'h0001;
                    if (rst_cnt_ff == rst_limit - 13'h0001) begin
                        nxt_state = ST_RUN;
                    end
                end
            end
            ST_RUN: begin
                nxt_rst_cnt = 13'h0000;
                if (timeout) begin
                    nxt_state = ST_RESET_HOLD;
                end
            end
            default: begin
                nxt_state = ST_SUPPLY_LOW;
            end
        endcase
        // Backup is not looked at here; a low supply alone holds reset.
        if (c.supply_below) begin
            nxt_state = ST_SUPPLY_LOW;
        end
        nxt_reset_n = (nxt_state == ST_RUN);
        nxt_supply_low_n = !c.supply_below;
        nxt_aux_fail_n = !c.aux_below;
        nxt_backup = c.supply_below && c.backup_below;
    end

    // ---------------------------------------------------------------
    // Chip-select gating.
    // ---------------------------------------------------------------
    always_comb begin
        nxt_cs = cs_ff;
        nxt_cs_cnt = 11'h000;
        case (cs_ff)
            CS_PASS: begin
                if (!reset_n_ff || c.supply_below) begin
                    nxt_cs = c.sel_in_n ? CS_BLOCK : CS_HOLD;
                end
            end
            CS_HOLD: begin
                nxt_cs_cnt = cs_cnt_ff + 11'h001;
                if (c.sel_in_n || cs_cnt_ff == CS_HOLD_CYC - 11'h001) begin
                    nxt_cs = CS_BLOCK;
                end
            end
            CS_BLOCK: begin
                if (reset_n_ff && !c.supply_below) begin
                    nxt_cs = CS_PASS;
                end
            end
            default: begin
                nxt_cs = CS_BLOCK;
            end
        endcase
        case (nxt_cs)
            CS_PASS: nxt_sel_out_n = c.sel_in_n;
            CS_HOLD: nxt_sel_out_n = 1'b0;
            default: nxt_sel_out_n = 1'b1;
        endcase
    end

    // ---------------------------------------------------------------
    // APB slave, zero wait states.
    // ---------------------------------------------------------------
    always_comb begin
        nxt_wd_en = wd_en_ff;
        nxt_prdata = prdata_ff;
        if (psel && penable && pwrite && reg_sel(paddr) == SEL_CTRL) begin
            nxt_wd_en = pwdata[CTRL_WD_EN_BIT];
        end
        if (psel && !penable) begin
            case (reg_sel(paddr))
                SEL_CTRL: nxt_prdata = {31'h0000_0000, wd_en_ff};
                SEL_STATUS: nxt_prdata = {24'h00_0000, first_ff, ext_mode, c.act_mid,
                                          aux_fail_n_ff, backup_ff, supply_low_n_ff,
                                          flag_ff, reset_n_ff};
                SEL_EVENTS: nxt_prdata = {24'h00_0000, evt_ff};
                default: nxt_prdata = 32'h0000_0000;
            endcase
        end
    end

    assign pready = 1'b1;
    assign pslverr = psel && penable && (reg_sel(paddr) == SEL_NONE ||
                     (pwrite && reg_sel(paddr) != SEL_CTRL));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= ST_SUPPLY_LOW;
            cs_ff <= CS_BLOCK;
            presc_ff <= 18'h0_0000;
            rst_cnt_ff <= 13'h0000;
            wd_cnt_ff <= 13'h0000;
            cs_cnt_ff <= 11'h000;
            pin_prev_ff <= 1'b0;
            act_prev_ff <= 1'b0;
            first_ff <= 1'b1;
            flag_ff <= 1'b1;
            reset_n_ff <= 1'b0;
            supply_low_n_ff <= 1'b0;
            aux_fail_n_ff <= 1'b0;
            backup_ff <= 1'b0;
            sel_out_n_ff <= 1'b1;
            wd_en_ff <= CTRL_WD_EN_RST;
            evt_ff <= EVENTS_RST;
            prdata_ff <= 32'h0000_0000;
        end else begin
            state_ff <= nxt_state;
            cs_ff <= nxt_cs;
            presc_ff <= nxt_presc;
            rst_cnt_ff <= nxt_rst_cnt;
            wd_cnt_ff <= nxt_wd_cnt;
            cs_cnt_ff <= nxt_cs_cnt;
            pin_prev_ff <= nxt_pin_prev;
            act_prev_ff <= nxt_act_prev;
            first_ff <= nxt_first;
            flag_ff <= nxt_flag;
            reset_n_ff <= nxt_reset_n;
            supply_low_n_ff <= nxt_supply_low_n;
            aux_fail_n_ff <= nxt_aux_fail_n;
            backup_ff <= nxt_backup;
            sel_out_n_ff <= nxt_sel_out_n;
            wd_en_ff <= nxt_wd_en;
            evt_ff <= nxt_evt;
            prdata_ff <= nxt_prdata;
        end
    end

    assign prdata = prdata_ff;
    assign reset_n = reset_n_ff;
    assign reset_hi_o = 1'b0;
    assign reset_hi_oe = reset_n_ff;
    assign supply_low_n = supply_low_n_ff;
    assign aux_fail_n = aux_fail_n_ff;
    assign backup_active = backup_ff;
    assign timeout_flag_n = flag_ff;
    assign select_out_n = sel_out_n_ff;

    // ---------------------------------------------------------------
    // Assertions.
    // ---------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_supply_low;
        c.supply_below |=> !supply_low_n && !reset_n;
    endproperty
    a_supply_low: assert property (p_supply_low) else $error("supply low not shown");

    property p_supply_back;
        !c.supply_below |=> supply_low_n;
    endproperty
    a_supply_back: assert property (p_supply_back) else $error("supply_low_n late");

    property p_aux;
        ##1 aux_fail_n == !$past(c.aux_below);
    endproperty
    a_aux: assert property (p_aux) else $error("aux_fail_n wrong");

    property p_open_drain;
        reset_hi_oe == reset_n && !reset_hi_o;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("high reset not inverse");

    property p_backup;
        backup_active |-> !reset_n && !supply_low_n;
    endproperty
    a_backup: assert property (p_backup) else $error("backup without reset");

    property p_flag_high;
        (c.supply_below || c.act_mid) |=> timeout_flag_n;
    endproperty
    a_flag_high: assert property (p_flag_high) else $error("flag low while disabled");

    property p_timeout;
        timeout |=> !timeout_flag_n && !reset_n && evt_ff == $past(evt_ff) + 8'h01;
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout not acted on");

    property p_flag_release;
        !timeout_flag_n && act_edge |=> timeout_flag_n;
    endproperty
    a_flag_release: assert property (p_flag_release) else $error("flag not released");

    property p_sel_pass;
        !select_out_n |-> $past(!c.sel_in_n);
    endproperty
    a_sel_pass: assert property (p_sel_pass) else $error("select low without request");

    property p_sel_hold;
        cs_ff == CS_HOLD |-> cs_cnt_ff < CS_HOLD_CYC;
    endproperty
    a_sel_hold: assert property (p_sel_hold) else $error("select held too long");

endmodule

// ===== tb/svwr_host_model.sv
`timescale 1ns/10ps
// -------------------------------------------------------------------
// Processor side: watchdog kicks and chip select.
// -------------------------------------------------------------------
module svwr_host_model #(
    parameter int HALF_CYC = 50
) (
    input wire logic pclk,
    input wire logic kick_en,
    input wire logic cs_req,
    output logic activity_input,
    output logic select_in_n
);
    int cnt = 0;
    initial activity_input = 1'b0;
    initial select_in_n = 1'b1;
    // Each level is held 500 ns, well above the 100 ns floor, so no kick is too short to count.
    always @(posedge pclk) begin
        cnt <= (kick_en && cnt < HALF_CYC - 1) ? cnt + 1 : 0;
        if (kick_en && cnt == HALF_CYC - 1) begin
            activity_input <= !activity_input;
        end
        select_in_n <= !cs_req;
    end
endmodule

// ===== tb/testbench.sv
`timescale 1ns/10ps
module testbench;
    import svwr_pkg::*;
    // A short tick keeps the 128-tick reset and 64-tick watchdog inside a brief run.
    localparam int TK = 4;
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic err;
    } svwr_row_type;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic sup_thr = 1'b1;
    logic sup_bk = 1'b1;
    logic aux = 1'b1;
    logic mid = 1'b0;
    logic src_sel = 1'b1;
    logic src_pin = 1'b0;
    logic kick_en = 1'b0;
    logic cs_req = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, act, sel_in_n, reset_n, reset_hi_o, reset_hi_oe;
    logic supply_low_n, aux_fail_n, backup_active, timeout_flag_n, select_out_n;
    // The high reset is open drain with a pull-up on the board.
    wire reset_hi = reset_hi_oe ? reset_hi_o : 1'b1;
    int n_fail = 0;
    int checked = 0;
    int cyc = 0;
    int n;
    int tot;
    logic [31:0] rd;
    logic er;
    svwr_row_type rows [8];

    svwr_supervisor #(.TICK_CYCLES(TK)) u_svwr_supervisor (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .supply_below_thr(sup_thr), .supply_below_backup(sup_bk), .aux_monitor_input(aux),
        .activity_mid(mid), .activity_input(act), .timing_source_select(src_sel),
        .timing_source_pin(src_pin), .select_in_n(sel_in_n), .reset_n(reset_n),
        .reset_hi_o(reset_hi_o), .reset_hi_oe(reset_hi_oe), .supply_low_n(supply_low_n),
        .aux_fail_n(aux_fail_n), .backup_active(backup_active),
        .timeout_flag_n(timeout_flag_n), .select_out_n(select_out_n)
    );
    svwr_host_model u_svwr_host_model (
        .pclk(pclk), .kick_en(kick_en), .cs_req(cs_req), .activity_input(act),
        .select_in_n(sel_in_n)
    );

    // -------------------------------------------------------------------
    // Tasks.
    // -------------------------------------------------------------------
    task complete_run();
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task chkb(input logic got, input logic exp, input string m);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s got %b", $time, m, got);
        end
    endtask
    task chkw(input logic [31:0] got, input logic [31:0] exp, input string m);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task rng(input int v, input int lo, input int hi, input string m);
        checked++;
        if (v < lo || v > hi) begin
            n_fail++;
            $display("unexpected at %0t: %s took %0d", $time, m, v);
        end
    endtask
    task wt(input int k);
        repeat (k) @(posedge pclk);
        @(negedge pclk);
    endtask
    // Counts settled samples until the chosen output shows the wanted level.
    task waitv(input int w, input logic v, input int lim, output int k);
        logic s;
        k = 0;
        do begin
            @(negedge pclk);
            k++;
            case (w)
                0: s = reset_n;
                1: s = supply_low_n;
                2: s = timeout_flag_n;
                default: s = select_out_n;
            endcase
        end while (s !== v && k < lim);
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // -------------------------------------------------------------------
    // Clock, hang limit and main sequence.
    // -------------------------------------------------------------------
    always #5 pclk = !pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_fail++;
            complete_run();
        end
    end

    initial begin
        rows = '{
            '{1'b0, 8'h00, 32'h0000_0000, 32'h0000_0001, 1'b0},
            '{1'b1, 8'h00, 32'h0000_0000, 32'h0000_0000, 1'b0},
            '{1'b0, 8'h00, 32'h0000_0000, 32'h0000_0000, 1'b0},
            '{1'b1, 8'h00, 32'h0000_0001, 32'h0000_0000, 1'b0},
            '{1'b0, 8'h08, 32'h0000_0000, 32'h0000_0000, 1'b0},
            '{1'b0, 8'h04, 32'h0000_0000, 32'h0000_008A, 1'b0},
            '{1'b0, 8'h0C, 32'h0000_0000, 32'h0000_0000, 1'b1},
            '{1'b1, 8'h04, 32'h0000_00FF, 32'h0000_0000, 1'b1}
        };
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        wt(4);
        chkb(supply_low_n, 1'b0, "low line");
        chkb(reset_n, 1'b0, "reset");
        chkb(reset_hi, 1'b1, "high reset");
        chkb(backup_active, 1'b1, "backup");
        chkb(aux_fail_n, 1'b0, "aux");
        chkb(timeout_flag_n, 1'b1, "flag");
        chkb(select_out_n, 1'b1, "select");
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].addr, rows[i].wdata, rd, er);
            chkb(er, rows[i].err, "slave error");
            if (!rows[i].wr) begin
                chkw(rd, rows[i].rdata, "read data");
            end
        end
        @(posedge pclk);
        sup_bk <= 1'b0;
        aux <= 1'b0;
        wt(4);
        chkb(backup_active, 1'b0, "backup off");
        chkb(reset_n, 1'b0, "reset without backup");
        chkb(aux_fail_n, 1'b1, "aux good");
        @(posedge pclk);
        sup_thr <= 1'b0;
        waitv(1, 1'b1, 20, n);
        rng(n, 2, 4, "low line rise");
        waitv(0, 1'b1, 700, tot);
        rng(n + tot, 128 * TK, 128 * TK + 12, "reset timeout");
        chkb(reset_hi, 1'b0, "high reset off");
        @(posedge pclk);
        aux <= 1'b1;
        cs_req <= 1'b1;
        kick_en <= 1'b1;
        wt(5000);
        chkb(aux_fail_n, 1'b0, "aux low");
        chkb(reset_n, 1'b1, "reset kept off");
        chkb(timeout_flag_n, 1'b1, "flag kept");
        chkb(select_out_n, 1'b0, "select passes");
        @(posedge pclk);
        kick_en <= 1'b0;
        waitv(0, 1'b0, 400, n);
        rng(n, 64 * TK - 52, 64 * TK + 12, "fast watchdog");
        chkb(timeout_flag_n, 1'b0, "flag low");
        // With the short tick the reset pulse ends well before the select hold does.
        waitv(0, 1'b1, 700, tot);
        rng(tot, 128 * TK - 4, 128 * TK + 8, "watchdog reset");
        waitv(3, 1'b1, 2000, n);
        rng(n + tot, 1596, 1604, "select hold");
        chkb(timeout_flag_n, 1'b0, "flag held");
        @(posedge pclk);
        kick_en <= 1'b1;
        waitv(2, 1'b1, 80, n);
        rng(n, 48, 58, "flag release");
        @(posedge pclk);
        mid <= 1'b1;
        kick_en <= 1'b0;
        wt(5000);
        chkb(timeout_flag_n, 1'b1, "flag at mid level");
        chkb(reset_n, 1'b1, "no reset at mid level");
        @(posedge pclk);
        mid <= 1'b0;
        sup_thr <= 1'b1;
        wt(5000);
        chkb(timeout_flag_n, 1'b1, "flag in low supply");
        chkb(select_out_n, 1'b1, "select blocked");
        chkb(reset_n, 1'b0, "reset in low supply");
        @(posedge pclk);
        src_sel <= 1'b0;
        sup_thr <= 1'b0;
        wt(2000);
        chkb(reset_n, 1'b0, "external source stalled");
        n = 0;
        while (reset_n !== 1'b1 && n < 2100) begin
            repeat (4) @(posedge pclk);
            src_pin <= 1'b1;
            repeat (4) @(posedge pclk);
            src_pin <= 1'b0;
            n++;
            @(negedge pclk);
        end
        rng(n, 2047, 2050, "external reset");
        complete_run();
    end
endmodule
